// ==== shared/lfsr_pkg.sv ====
// package: constants and types for the laser fault safety/reset block
// assumes: both ends, the checker and the bench import it
package lfsr_pkg;
  localparam int unsigned LFSR_CLK_MHZ = 200;
  localparam int unsigned LFSR_RESET_TIME_US = 50;
  localparam int unsigned LFSR_RESET_CYCLES =
    LFSR_RESET_TIME_US * LFSR_CLK_MHZ;
  localparam logic [6:0] LFSR_ADDR_MODE = 7'h00;
  localparam logic [6:0] LFSR_ADDR_TXCFG = 7'h01;
  localparam logic [6:0] LFSR_ADDR_MASK = 7'h02;
  localparam logic [6:0] LFSR_ADDR_STAT = 7'h03;
  localparam logic [6:0] LFSR_ADDR_DPC = 7'h04;
  localparam logic [6:0] LFSR_ADDR_MON = 7'h05;
  localparam logic [6:0] LFSR_ADDR_CEIL = 7'h06;
  localparam logic [6:0] LFSR_ADDR_MCEIL = 7'h08;
  localparam logic [7:0] LFSR_MODE_NORMAL = 8'h00;
  localparam logic [7:0] LFSR_MODE_SETUP = 8'h12;
  localparam logic [7:0] LFSR_MODE_FCLR = 8'h68;
  // txcfg fields
  localparam int unsigned LFSR_TXEN_BIT = 0;
  localparam int unsigned LFSR_DPOL_BIT = 1;
  localparam int unsigned LFSR_SRST_BIT = 7;
  localparam logic [7:0] LFSR_TXCFG_RST = 8'h03;
  localparam logic [7:0] LFSR_MASK_RST = 8'h00;
  // status / mask bit positions
  localparam int unsigned LFSR_F_INLOS = 0;
  localparam int unsigned LFSR_F_PD = 1;
  localparam int unsigned LFSR_F_BIAS = 2;
  localparam int unsigned LFSR_F_SUPLO = 3;
  localparam int unsigned LFSR_F_MOD = 4;
  localparam int unsigned LFSR_ST_LATCH = 5;
  localparam int unsigned LFSR_ST_RSTBUSY = 6;
  // dpc fields
  localparam int unsigned LFSR_LOOP_RUN_CMD_BIT = 0;
  localparam int unsigned LFSR_DPC_RESTART_BIT = 1;
  localparam logic [7:0] LFSR_DPC_RST = 8'h00;
  // monitor fields: [0] source select, [1] mirror enable, [3:2] gain
  localparam int unsigned LFSR_MONITOR_SOURCE_SELECT_BIT = 0;
  localparam int unsigned LFSR_MON_MIR_BIT = 1;
  localparam logic [7:0] LFSR_MON_RST = 8'h00;
  localparam logic [7:0] LFSR_CEIL_RST = 8'hFF;
  // synchroniser idle: supply low and disable high until first sampled
  localparam logic [7:0] LFSR_SYNC_RST = 8'h81;
  localparam int unsigned LFSR_NFAULT = 5;
  localparam logic [31:0] LFSR_APB_CMD = 32'h0000_0000;
  localparam logic [31:0] LFSR_APB_STAT = 32'h0000_0004;
  localparam logic [31:0] LFSR_APB_RDATA = 32'h0000_0008;
  // analog monitor selection codes
  typedef enum logic [1:0] {
    LFSR_MON_BIAS = 2'b00,
    LFSR_MON_PD = 2'b01,
    LFSR_MON_OFF = 2'b10
  } lfsr_mon_t;
endpackage

// ==== shared/lfsr_if.sv ====
// interface: register word port, disable pin and status between the ends
// assumes: a single pclk domain on both sides
`timescale 1ns/1ps
`default_nettype none
interface lfsr_if;
  logic req;
  logic wr;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  logic disable_pin;
  logic fault_pin;
  modport device (input req, wr, addr, wdata, disable_pin,
    output rdata, ack, fault_pin);
  modport ctrl (output req, wr, addr, wdata, disable_pin,
    input rdata, ack, fault_pin);
endinterface
`default_nettype wire

// ==== logic/lfsr_device.sv ====
// laser transmitter fault supervisor and reset sequencer (device end)
// assumes: analog detector outputs arrive asynchronous and are synchronised
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module lfsr_device
  import lfsr_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = LFSR_RESET_CYCLES
)(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller side
  lfsr_if.device bus,
  // analog supervisors (asynchronous)
  input wire logic supply_ok,
  input wire logic tx_data_stuck,
  input wire logic photodiode_short_gnd,
  input wire logic photodiode_open_high,
  input wire logic bias_pin_bad,
  input wire logic mod_pin_bad,
  input wire logic tx_output_supply_ok,
  // driver controls
  output logic bias_dac_enable,
  output logic mod_dac_enable,
  output logic drive_ceiling_limit,
  output logic [7:0] bias_ceiling,
  output logic [7:0] mod_ceiling,
  output logic dual_loop_run,
  output lfsr_mon_t monitor_route,
  output logic [1:0] photodiode_current_gain,
  output logic reset_busy
);
  // elaboration refuses a zero-length reset sequence
  if (RESET_CYCLES < 1) $error("RESET_CYCLES must be at least 1");

  localparam int NS = 8;
  logic [NS-1:0] s1_reg, s2_reg;
  logic [NS-1:0] raw;
  assign raw = {bus.disable_pin, ~tx_output_supply_ok, mod_pin_bad,
    photodiode_open_high, bias_pin_bad, photodiode_short_gnd,
    tx_data_stuck, ~supply_ok};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // idle levels, so no false disable edge follows reset
      s1_reg <= LFSR_SYNC_RST;
      s2_reg <= LFSR_SYNC_RST;
    end
    else
    begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end
  logic supply_low, dis_pin;
  assign supply_low = s2_reg[0] | s2_reg[6];
  assign dis_pin = s2_reg[7];

  logic [7:0] txcfg_reg, mask_reg, dpc_reg, mon_reg, bceil_reg, mceil_reg;
  logic [4:0] flag_reg;
  logic latch_reg, loop_halt_reg, dis_prev_reg;
  logic [$clog2(RESET_CYCLES+1)-1:0] rcnt_reg;
  logic soft_rst, por_hold, in_rst, wr_hit, fault_clear, trip;
  logic [4:0] det;

  assign por_hold = s2_reg[0];
  // take each write once: req still stands in the ack cycle
  assign wr_hit = bus.req & bus.wr & ~bus.ack & ~in_rst;
  assign soft_rst = wr_hit & (bus.addr == LFSR_ADDR_TXCFG) &
    bus.wdata[LFSR_SRST_BIT];
  assign in_rst = por_hold | (rcnt_reg != '0);

  // reset timer: held while main supply (supply_ok) low, counts down after
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rcnt_reg <= $bits(rcnt_reg)'(RESET_CYCLES);
    else if (por_hold | soft_rst)
      rcnt_reg <= $bits(rcnt_reg)'(RESET_CYCLES);
    else if (rcnt_reg != '0)
      rcnt_reg <= rcnt_reg - 1'b1;
  end
  assign reset_busy = in_rst;

  // configuration registers; any reset loads defaults
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txcfg_reg <= LFSR_TXCFG_RST;
      mask_reg <= LFSR_MASK_RST;
      mon_reg <= LFSR_MON_RST;
      bceil_reg <= LFSR_CEIL_RST;
      mceil_reg <= LFSR_CEIL_RST;
    end
    else if (in_rst | soft_rst)
    begin
      txcfg_reg <= LFSR_TXCFG_RST;
      mask_reg <= LFSR_MASK_RST;
      mon_reg <= LFSR_MON_RST;
      bceil_reg <= LFSR_CEIL_RST;
      mceil_reg <= LFSR_CEIL_RST;
    end
    else if (wr_hit)
    begin
      unique case (bus.addr)
        LFSR_ADDR_TXCFG: txcfg_reg <= {1'b0, bus.wdata[6:0]};
        LFSR_ADDR_MASK: mask_reg <= {3'b000, bus.wdata[4:0]};
        LFSR_ADDR_MON: mon_reg <= {4'h0, bus.wdata[3:0]};
        LFSR_ADDR_CEIL: bceil_reg <= bus.wdata;
        LFSR_ADDR_MCEIL: mceil_reg <= bus.wdata;
        default: ;
      endcase
    end
  end

  // fault detection and latching
  assign det[LFSR_F_INLOS] = s2_reg[1];
  assign det[LFSR_F_PD] = s2_reg[2];
  assign det[LFSR_F_BIAS] = s2_reg[3];
  assign det[LFSR_F_SUPLO] = s2_reg[6];
  assign det[LFSR_F_MOD] = s2_reg[5];
  assign trip = |(det & ~mask_reg[4:0]);
  // a rising or falling disable edge both count as a toggle
  assign fault_clear = (dis_pin != dis_prev_reg) |
    (wr_hit & (bus.addr == LFSR_ADDR_MODE) &
    (bus.wdata == LFSR_MODE_FCLR));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dis_prev_reg <= 1'b1;
    else
      dis_prev_reg <= dis_pin;
  end

  // flags and latch: a detection in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_reg <= '0;
      latch_reg <= 1'b0;
    end
    else if (in_rst)
    begin
      flag_reg <= det | {1'b0, supply_low, 3'b000};
      latch_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= (fault_clear ? 5'b00000 : flag_reg) | det;
      latch_reg <= (latch_reg & ~fault_clear) | trip;
    end
  end

  // loop run control: photodiode fault halts regardless of mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dpc_reg <= LFSR_DPC_RST;
      loop_halt_reg <= 1'b0;
    end
    else if (in_rst)
    begin
      dpc_reg <= LFSR_DPC_RST;
      loop_halt_reg <= 1'b0;
    end
    else if (det[LFSR_F_PD] | trip)
    begin
      loop_halt_reg <= 1'b1;
      dpc_reg[LFSR_LOOP_RUN_CMD_BIT] <= 1'b0;
    end
    else if (wr_hit & (bus.addr == LFSR_ADDR_DPC) &
      (bus.wdata[LFSR_LOOP_RUN_CMD_BIT] | bus.wdata[LFSR_DPC_RESTART_BIT]))
    begin
      loop_halt_reg <= 1'b0;
      dpc_reg[LFSR_LOOP_RUN_CMD_BIT] <= 1'b1;
    end
  end

  logic tx_off;
  // default polarity: high (or floating, pulled high) disables
  assign tx_off = txcfg_reg[LFSR_DPOL_BIT] ? dis_pin : ~dis_pin;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bias_dac_enable <= 1'b0;
      mod_dac_enable <= 1'b0;
      bus.fault_pin <= 1'b0;
      drive_ceiling_limit <= 1'b0;
      dual_loop_run <= 1'b0;
    end
    else
    begin
      bias_dac_enable <= ~in_rst & ~latch_reg & ~trip & ~tx_off &
        txcfg_reg[LFSR_TXEN_BIT] & ~det[LFSR_F_SUPLO];
      mod_dac_enable <= ~in_rst & ~latch_reg & ~trip & ~tx_off &
        txcfg_reg[LFSR_TXEN_BIT] & ~det[LFSR_F_SUPLO];
      bus.fault_pin <= latch_reg;
      drive_ceiling_limit <= s2_reg[4];
      dual_loop_run <= dpc_reg[LFSR_LOOP_RUN_CMD_BIT] & ~loop_halt_reg;
    end
  end
  assign bias_ceiling = bceil_reg;
  assign mod_ceiling = mceil_reg;
  assign photodiode_current_gain = mon_reg[3:2];

  // analog monitor routing
  always_comb
  begin
    if (!mon_reg[LFSR_MONITOR_SOURCE_SELECT_BIT])
      monitor_route = LFSR_MON_BIAS;
    else if (mon_reg[LFSR_MON_MIR_BIT])
      monitor_route = LFSR_MON_PD;
    else
      monitor_route = LFSR_MON_OFF;
  end

  // read port: one-cycle ack, data registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus.ack <= 1'b0;
      bus.rdata <= 8'h00;
    end
    else
    begin
      bus.ack <= bus.req & ~bus.ack;
      if (bus.req & ~bus.wr)
      begin
        unique case (bus.addr)
          LFSR_ADDR_TXCFG: bus.rdata <= txcfg_reg;
          LFSR_ADDR_MASK: bus.rdata <= mask_reg;
          LFSR_ADDR_STAT: bus.rdata <= {1'b0, in_rst, latch_reg,
            flag_reg | {1'b0, supply_low, 3'b000}};
          LFSR_ADDR_DPC: bus.rdata <= {7'h00, dual_loop_run};
          LFSR_ADDR_MON: bus.rdata <= mon_reg;
          LFSR_ADDR_CEIL: bus.rdata <= bceil_reg;
          default: bus.rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/lfsr_ctrl.sv ====
// controller end: APB slave commands turned into register word transfers
// assumes: device answers each request with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
module lfsr_ctrl
  import lfsr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device side
  lfsr_if.ctrl link
);
  // cmd word: [17] drive disable pin, [16] read, [14:8] addr, [7:0] data
  typedef enum logic [1:0] {
    LFSR_C_IDLE = 2'b00,
    LFSR_C_REQ = 2'b01
  } lfsr_cst_t;
  lfsr_cst_t st_reg;
  logic [7:0] rd_reg;
  logic dis_reg;
  logic busy;
  logic cmd_wr;
  assign busy = (st_reg == LFSR_C_REQ);
  assign cmd_wr = psel & penable & pwrite & (paddr == LFSR_APB_CMD);

  // software sets the disable pin before a soft reset write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg <= LFSR_C_IDLE;
      link.req <= 1'b0;
      link.wr <= 1'b0;
      link.addr <= 7'h00;
      link.wdata <= 8'h00;
      dis_reg <= 1'b1;
      rd_reg <= 8'h00;
    end
    else
    begin
      unique case (st_reg)
        LFSR_C_IDLE:
          if (cmd_wr)
          begin
            dis_reg <= pwdata[17];
            link.req <= 1'b1;
            link.wr <= ~pwdata[16];
            link.addr <= pwdata[14:8];
            link.wdata <= pwdata[7:0];
            st_reg <= LFSR_C_REQ;
          end
        LFSR_C_REQ:
          if (link.ack)
          begin
            link.req <= 1'b0;
            rd_reg <= link.rdata;
            st_reg <= LFSR_C_IDLE;
          end
        default: st_reg <= LFSR_C_IDLE;
      endcase
    end
  end
  assign link.disable_pin = dis_reg;

  // polling and init sequencing done by software via stat
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always_comb
  begin
    unique case (paddr)
      LFSR_APB_STAT: prdata = {30'h0, link.fault_pin, busy};
      LFSR_APB_RDATA: prdata = {24'h0, rd_reg};
      default: prdata = 32'h0000_0000;
    endcase
  end
endmodule
`default_nettype wire

// ==== dv/lfsr_properties.sv ====
// checker: timing relations on the link between controller and device
// assumes: instantiated in the bench beside the link interface
`timescale 1ns/1ps
`default_nettype none
module lfsr_properties
  import lfsr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link signals
  input wire logic req,
  input wire logic wr,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic disable_pin,
  input wire logic fault_pin
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic dis_reg;
  logic [3:0] age_reg;
  logic fclr;
  logic clr;
  assign fclr = ack && wr && addr == LFSR_ADDR_MODE &&
    wdata == LFSR_MODE_FCLR;
  // soft reset and any disable edge drop the latch as well
  assign clr = fclr || disable_pin != dis_reg ||
    (ack && wr && addr == LFSR_ADDR_TXCFG && wdata[LFSR_SRST_BIT]);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dis_reg <= 1'b1;
      age_reg <= 4'hF;
    end
    else
    begin
      dis_reg <= disable_pin;
      if (clr)
        age_reg <= 4'h0;
      else if (age_reg != 4'hF)
        age_reg <= age_reg + 4'h1;
    end
  end
  a_ack_follows_req: assert property ($rose(req) |=> ack)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_release: assert property (ack |=> !req)
    else $error("request held after ack");
  a_ack_has_req: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_req_holds: assert property (req && !ack |=> req && $stable(addr)
    && $stable(wdata) && $stable(wr))
    else $error("request changed before ack");
  a_reset_safe: assert property ($rose(presetn) |-> disable_pin &&
    !fault_pin)
    else $error("unsafe state after reset");
  a_fclr_drops: assert property (fclr |-> ##[1:8] !fault_pin)
    else $error("fault pin kept after fault clear");
  a_fault_holds: assert property ($fell(fault_pin) |-> age_reg < 4'hC)
    else $error("fault pin fell without a clear");
  c_read: cover property (ack && !wr);
  c_trip: cover property ($rose(fault_pin));
  c_clear: cover property (fclr ##1 !fault_pin);
endmodule
`default_nettype wire

// ==== dv/laser_fault_safety_reset_tb.sv ====
// bench: APB commands through the controller to the device end
// assumes: designs of both ends, link interface and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module laser_fault_safety_reset_tb
  import lfsr_pkg::*;
;
  localparam int RST_N = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic supply_ok, tx_data_stuck, photodiode_short_gnd;
  logic photodiode_open_high, bias_pin_bad, mod_pin_bad;
  logic tx_output_supply_ok, bias_dac_enable, mod_dac_enable;
  logic drive_ceiling_limit, dual_loop_run, reset_busy, dis;
  logic [7:0] bias_ceiling, mod_ceiling, rd;
  logic [1:0] photodiode_current_gain;
  lfsr_mon_t monitor_route;
  int bad_count, checks;
  lfsr_if link_if();
  lfsr_device #(.RESET_CYCLES(RST_N)) lfsr_device_inst (.pclk, .presetn,
    .bus(link_if), .supply_ok, .tx_data_stuck, .photodiode_short_gnd,
    .photodiode_open_high, .bias_pin_bad, .mod_pin_bad,
    .tx_output_supply_ok, .bias_dac_enable, .mod_dac_enable,
    .drive_ceiling_limit, .bias_ceiling, .mod_ceiling, .dual_loop_run,
    .monitor_route, .photodiode_current_gain, .reset_busy);
  lfsr_ctrl lfsr_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link_if));
  lfsr_properties lfsr_properties_inst (.pclk, .presetn,
    .req(link_if.req), .wr(link_if.wr), .addr(link_if.addr),
    .wdata(link_if.wdata), .ack(link_if.ack),
    .disable_pin(link_if.disable_pin), .fault_pin(link_if.fault_pin));
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang(string nm);
    bad_count++;
    $display("unexpected %s expected done seen timeout", nm);
    test_done();
  endtask
  task automatic apb(logic w, logic [31:0] a, output logic [31:0] r,
    input logic [31:0] d = 32'h0);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    chk("pslverr", pslverr, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      hang("pready");
  endtask
  // one link transfer; the disable pin level rides along in every command
  task automatic cmd(logic rdn, logic [6:0] a, logic [7:0] d = 8'h00);
    logic [31:0] r;
    int n;
    apb(1'b1, LFSR_APB_CMD, r, {14'h0, dis, rdn, 1'b0, a, d});
    n = 0;
    do
    begin
      apb(1'b0, LFSR_APB_STAT, r);
      n++;
    end while (r[0] !== 1'b0 && n < 50);
    if (r[0] !== 1'b0)
      hang("link busy");
    apb(1'b0, LFSR_APB_RDATA, r);
    rd = r[7:0];
  endtask
  task automatic wait_idle(output int n);
    n = 0;
    while (reset_busy !== 1'b0 && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (reset_busy !== 1'b0)
      hang("reset busy");
  endtask
  task automatic det(int i, logic v);
    case (i)
      0: tx_data_stuck <= v;
      1: photodiode_short_gnd <= v;
      2: bias_pin_bad <= v;
      3: tx_output_supply_ok <= !v;
      default: mod_pin_bad <= v;
    endcase
  endtask
  task automatic poll(int i);
    int n;
    n = 0;
    do
    begin
      cmd(1'b1, LFSR_ADDR_STAT);
      n++;
    end while (rd[i] !== 1'b1 && n < 20);
    if (rd[i] !== 1'b1)
      hang("status flag");
  endtask
  task automatic t_reset();
    int n;
    chk("busy_low_supply", reset_busy, 1);
    chk("bias_low_supply", bias_dac_enable, 0);
    cmd(1'b1, LFSR_ADDR_STAT);
    chk("stat_supply_low", rd, 8'h48);
    chk("bias_during_read", bias_dac_enable, 0);
    supply_ok <= 1'b1;
    wait_idle(n);
    chk("reset_length", n >= RST_N, 1);
    cmd(1'b1, LFSR_ADDR_TXCFG);
    chk("txcfg_default", rd, LFSR_TXCFG_RST);
    cmd(1'b1, LFSR_ADDR_MASK);
    chk("mask_default", rd, LFSR_MASK_RST);
    chk("route_default", monitor_route, LFSR_MON_BIAS);
    dis = 1'b0;
    cmd(1'b1, LFSR_ADDR_STAT);
    chk("stat_clean", rd, 8'h00);
    chk("bias_enabled", bias_dac_enable, 1);
    $display("test reset done");
  endtask
  task automatic t_monitor();
    int n;
    cmd(1'b0, LFSR_ADDR_MON, 8'h0B);
    chk("route_pd", monitor_route, LFSR_MON_PD);
    chk("pd_gain", photodiode_current_gain, 2'b10);
    cmd(1'b0, LFSR_ADDR_MON, 8'h01);
    chk("route_off", monitor_route, LFSR_MON_OFF);
    cmd(1'b0, LFSR_ADDR_CEIL, 8'h5A);
    chk("bias_ceiling", bias_ceiling, 8'h5A);
    cmd(1'b0, LFSR_ADDR_MCEIL, 8'hA5);
    chk("mod_ceiling", mod_ceiling, 8'hA5);
    photodiode_open_high <= 1'b1;
    for (n = 0; n < 20 && drive_ceiling_limit !== 1'b1; n++)
      @(posedge pclk);
    chk("ceiling_limit", drive_ceiling_limit, 1);
    photodiode_open_high <= 1'b0;
    $display("test monitor done");
  endtask
  task automatic t_faults();
    for (int i = 0; i < LFSR_NFAULT; i++)
    begin
      det(i, 1'b1);
      poll(i);
      det(i, 1'b0);
      chk("bias_tripped", bias_dac_enable, 0);
      chk("mod_tripped", mod_dac_enable, 0);
      chk("fault_held", link_if.fault_pin, 1);
      cmd(1'b1, LFSR_ADDR_STAT);
      chk("stat_flags", rd, 8'h20 | (8'h01 << i));
      // even sources clear by command, odd ones by a disable toggle
      if (i % 2 == 0)
        cmd(1'b0, LFSR_ADDR_MODE, LFSR_MODE_FCLR);
      else
      begin
        dis = 1'b1;
        cmd(1'b1, LFSR_ADDR_STAT);
        dis = 1'b0;
        cmd(1'b1, LFSR_ADDR_STAT);
      end
      cmd(1'b1, LFSR_ADDR_STAT);
      chk("stat_cleared", rd, 8'h00);
      chk("fault_clear", link_if.fault_pin, 0);
      chk("bias_restored", bias_dac_enable, 1);
    end
    $display("test faults done");
  endtask
  task automatic t_mask();
    cmd(1'b0, LFSR_ADDR_MASK, 8'h1F);
    cmd(1'b0, LFSR_ADDR_DPC, 8'h01);
    chk("loop_running", dual_loop_run, 1);
    det(1, 1'b1);
    poll(1);
    det(1, 1'b0);
    chk("masked_bias", bias_dac_enable, 1);
    chk("masked_fault", link_if.fault_pin, 0);
    chk("loop_halted", dual_loop_run, 0);
    cmd(1'b0, LFSR_ADDR_DPC, 8'h02);
    chk("loop_restart", dual_loop_run, 1);
    cmd(1'b0, LFSR_ADDR_MODE, LFSR_MODE_FCLR);
    $display("test mask done");
  endtask
  task automatic t_polarity();
    cmd(1'b0, LFSR_ADDR_TXCFG, 8'h01);
    chk("low_pin_off", bias_dac_enable, 0);
    dis = 1'b1;
    cmd(1'b1, LFSR_ADDR_STAT);
    chk("high_pin_on", bias_dac_enable, 1);
    $display("test polarity done");
  endtask
  task automatic t_soft();
    int n;
    cmd(1'b0, LFSR_ADDR_TXCFG, 8'h03);
    cmd(1'b0, LFSR_ADDR_MASK, 8'h15);
    chk("tx_held_off", bias_dac_enable, 0);
    cmd(1'b0, LFSR_ADDR_TXCFG, 8'h83);
    chk("soft_busy", reset_busy, 1);
    wait_idle(n);
    cmd(1'b1, LFSR_ADDR_MASK);
    chk("mask_reloaded", rd, LFSR_MASK_RST);
    chk("route_reloaded", monitor_route, LFSR_MON_BIAS);
    chk("ceil_reloaded", bias_ceiling, LFSR_CEIL_RST);
    chk("mceil_reloaded", mod_ceiling, LFSR_CEIL_RST);
    $display("test soft reset done");
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {supply_ok, tx_data_stuck, photodiode_short_gnd} = '0;
    {photodiode_open_high, bias_pin_bad, mod_pin_bad} = '0;
    tx_output_supply_ok = 1'b1;
    dis = 1'b1;
    bad_count = 0;
    checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_monitor();
    t_faults();
    t_mask();
    t_polarity();
    t_soft();
    test_done();
  end
endmodule
`default_nettype wire
